//--- bench/gpio_ports_props.sv
// assertions on the pin outputs and read port of ports zero to two
`timescale 1ns/1ns
module gpio_ports_props (
  input wire logic                            sys_clk,
  input wire logic                            rstn,
  input wire logic                            ce,
  input wire logic                            wr_en,
  input wire logic [gpio_pkg::sel_w-1:0]      wr_sel,
  input wire logic [gpio_pkg::data_w-1:0]     wr_data,
  input wire logic [gpio_pkg::data_w-1:0]     wr_mask,
  input wire logic [gpio_pkg::sel_w-1:0]      rd_sel,
  input wire logic [gpio_pkg::data_w-1:0]     rd_data,
  input wire logic [gpio_pkg::width_zero-1:0] port0_oe,
  input wire logic [gpio_pkg::width_zero-1:0] port0_pullup,
  input wire logic [gpio_pkg::width_one-1:0]  port1_out,
  input wire logic [gpio_pkg::width_one-1:0]  port1_oe,
  input wire logic [gpio_pkg::width_one-1:0]  port1_pullup,
  input wire logic [gpio_pkg::width_two-1:0]  port2_oe,
  input wire logic [gpio_pkg::width_two-1:0]  port2_convert
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // byte write to the port-one latch or direction, then one running cycle
  sequence s_lat1;
    ce && wr_en && wr_sel == 4'h1 && wr_mask == 8'hff ##1 ce;
  endsequence
  sequence s_dir1;
    ce && wr_en && wr_sel == 4'h6 && wr_mask == 8'hff ##1 ce;
  endsequence

  property p_lat1_out;
    s_lat1 |=> port1_out == $past(wr_data, 2);
  endproperty
  a_lat1_out: assert property (p_lat1_out)
    else $error("port one output differs from written latch");
  property p_dir1_oe;
    s_dir1 |=> port1_oe == ~$past(wr_data, 2);
  endproperty
  a_dir1_oe: assert property (p_dir1_oe)
    else $error("port one enable differs from written direction");
  property p_pull1_off;
    (port1_pullup & port1_oe) == 8'h00;
  endproperty
  a_pull1_off: assert property (p_pull1_off)
    else $error("port one pull-up on a driven pin");
  property p_pull0_off;
    (port0_pullup & port0_oe) == 2'b00;
  endproperty
  a_pull0_off: assert property (p_pull0_off)
    else $error("port zero pull-up on a driven pin");
  property p_conv_one;
    $onehot0(port2_convert);
  endproperty
  a_conv_one: assert property (p_conv_one)
    else $error("more than one port-two pin converted");
  property p_conv_drv;
    (port2_convert & port2_oe) == 8'h00;
  endproperty
  a_conv_drv: assert property (p_conv_drv)
    else $error("port-two pin converted while driven");
  property p_rst_in;
    $rose(rstn) |-> port0_oe == 2'b00 && port1_oe == 8'h00
      && port2_oe == 8'h00;
  endproperty
  a_rst_in: assert property (p_rst_in)
    else $error("pin driven right after reset");
  property p_unmapped;
    ce && rd_sel == 4'hf |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_freeze;
    !ce |=> $stable(port1_out) && $stable(port1_oe);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("port one changed while stopped");
endmodule // gpio_ports_props

bind gpio_ports gpio_ports_props i_gpio_ports_props (.*);

//--- bench/pin_model.sv
// far-side pin model: chip drive, outside driver, pull-up or floating
`timescale 1ns/1ns
module pin_model #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  logic [W-1:0] flt = '0;

  // a floating pin changes every cycle so a stale level never looks valid
  always @(posedge sys_clk) flt <= ~flt;

  // chip drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++)
      pin[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : flt[i];
  end
endmodule // pin_model

//--- bench/tb_top.sv
// self-checking bench for the general-purpose ports zero to four
`timescale 1ns/1ns
module tb_top;
  logic       sys_clk, rstn, ce, wr_en, port2_bad_cfg;
  logic [3:0] wr_sel, rd_sel;
  logic [7:0] wr_data, wr_mask, rd_data, port2_convert;
  logic [2:0] converter_channel_select;
  logic [1:0] port0_in, port0_out, port0_oe, port0_pullup, x0, xe0;
  logic [7:0] port1_in, port1_out, port1_oe, port1_pullup, x1, xe1;
  logic [7:0] port2_in, port2_out, port2_oe, x2, xe2, pull2;
  logic [3:0] port3_in, port3_out, port3_oe, port3_pullup, x3, xe3;
  logic [1:0] port4_in, port4_out, port4_oe, port4_pullup, x4, xe4;
  int         err_total, comparisons;

  gpio_ports i_gpio_ports (.*);

  // pins on the far side of every port
  pin_model #(.W(2)) i_pin_model_0 (.sys_clk, .out(port0_out),
    .oe(port0_oe), .pull(port0_pullup), .ext(x0), .ext_en(xe0),
    .pin(port0_in));
  pin_model #(.W(8)) i_pin_model_1 (.sys_clk, .out(port1_out),
    .oe(port1_oe), .pull(port1_pullup), .ext(x1), .ext_en(xe1),
    .pin(port1_in));
  pin_model #(.W(8)) i_pin_model_2 (.sys_clk, .out(port2_out),
    .oe(port2_oe), .pull(pull2), .ext(x2), .ext_en(xe2), .pin(port2_in));
  pin_model #(.W(4)) i_pin_model_3 (.sys_clk, .out(port3_out),
    .oe(port3_oe), .pull(port3_pullup), .ext(x3), .ext_en(xe3),
    .pin(port3_in));
  pin_model #(.W(2)) i_pin_model_4 (.sys_clk, .out(port4_out),
    .oe(port4_oe), .pull(port4_pullup), .ext(x4), .ext_en(xe4),
    .pin(port4_in));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] s, input logic [7:0] d,
                    input logic [7:0] m);
    @(posedge sys_clk);
    #1;
    wr_en = 1'b1;
    wr_sel = s;
    wr_data = d;
    wr_mask = m;
    @(posedge sys_clk);
    #1;
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] s, input logic [7:0] e);
    @(posedge sys_clk);
    #1;
    rd_sel = s;
    repeat (3) @(posedge sys_clk);
    #1;
    cmp($sformatf("rd_data sel %h", s), e, rd_data);
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic done(input string nm);
    $display("test %s over, mismatches %0d", nm, err_total);
  endtask

  // reset with every pin held low from outside, then read every select
  task automatic do_reset;
    {x0, x1, x2, x3, x4, pull2} = '0;
    {xe0, xe1, xe2, xe3, xe4} = '1;
    rstn = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp("oe ports 0 3 4", 8'h00, {port0_oe, port3_oe, port4_oe});
    cmp("port1_oe", 8'h00, port1_oe);
    cmp("port2_oe", 8'h00, port2_oe);
    rstn = 1'b1;
    for (int s = 0; s < 16; s++)
      rd(4'(s), s < 5 ? 8'h00 : s < 10 ? 8'hff : 8'h00);
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #20000;
    err_total++;
    $display("watchdog expired");
    summarize();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    wr_sel = 4'h0;
    wr_data = 8'h00;
    wr_mask = 8'h00;
    rd_sel = 4'h0;
    converter_channel_select = 3'h0;
    do_reset();
    done("reset values");
    // port zero: bit 0 output by a single-bit write, bit 1 input held high
    x0 = 2'b10;
    wr(4'h5, 8'h00, 8'h01);
    wr(4'h0, 8'h03, 8'hff);
    wr(4'ha, 8'h03, 8'hff);
    settle();
    cmp("port0 pull and oe", 8'h09, {4'h0, port0_pullup, port0_oe});
    cmp("port0_out", 8'h03, {6'h00, port0_out});
    rd(4'h0, 8'h03);
    rd(4'h5, 8'hfe);
    done("port zero");
    // port one: upper half floating inputs with pull-up, lower half output
    xe1 = 8'h00;
    wr(4'hb, 8'hff, 8'hff);
    wr(4'h1, 8'ha5, 8'hff);
    wr(4'h6, 8'hf0, 8'hff);
    settle();
    cmp("port1_pullup", 8'hf0, port1_pullup);
    cmp("port1_oe", 8'h0f, port1_oe);
    cmp("port1_out", 8'ha5, port1_out);
    rd(4'h1, 8'hf5);
    rd(4'h6, 8'hf0);
    // a write while stopped is ignored
    ce = 1'b0;
    wr(4'h1, 8'h00, 8'hff);
    settle();
    cmp("port1_out held", 8'ha5, port1_out);
    ce = 1'b1;
    rd(4'h1, 8'hf5);
    done("port one");
    // ports three and four: outputs and a pin read through the pull-up
    x4 = 2'b01;
    xe3 = 4'h0;
    xe4 = 2'b10;
    wr(4'hc, 8'h0f, 8'hff);
    wr(4'h8, 8'h00, 8'hff);
    wr(4'h3, 8'h0a, 8'hff);
    wr(4'h9, 8'h00, 8'h02);
    wr(4'h4, 8'h02, 8'hff);
    wr(4'hd, 8'h03, 8'hff);
    settle();
    cmp("port3_oe", 8'h0f, {4'h0, port3_oe});
    cmp("port4_pullup", 8'h01, {6'h00, port4_pullup});
    cmp("port3_pullup", 8'h00, {4'h0, port3_pullup});
    cmp("port3_out", 8'h0a, {4'h0, port3_out});
    cmp("port4 out and oe", 8'h0a, {4'h0, port4_out, port4_oe});
    rd(4'h8, 8'hf0);
    rd(4'h3, 8'h0a);
    rd(4'h9, 8'hfd);
    rd(4'h4, 8'h03);
    done("ports three and four");
    // port two: low four pins digital from bit 0 up, two of them outputs
    // pin 3 left to a board pull-up, the rest driven from outside
    x2 = 8'h3c;
    xe2 = 8'hf7;
    pull2 = 8'h08;
    wr(4'he, 8'h0f, 8'hff);
    wr(4'h7, 8'h00, 8'h03);
    wr(4'h2, 8'hff, 8'hff);
    settle();
    cmp("port2_oe", 8'h03, port2_oe);
    cmp("port2_out", 8'hff, port2_out);
    rd(4'h2, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      converter_channel_select = 3'(c);
      settle();
      cmp("port2_convert", c > 3 ? 8'h01 << c : 8'h00, port2_convert);
    end
    // analog pin set to output is flagged, not driven, not converted
    wr(4'h7, 8'h00, 8'h80);
    settle();
    cmp("port2_bad_cfg", 8'h01, {7'h00, port2_bad_cfg});
    cmp("port2_oe bad", 8'h03, port2_oe);
    cmp("port2_convert bad", 8'h00, port2_convert);
    wr(4'h7, 8'h80, 8'h80);
    settle();
    cmp("port2_bad_cfg off", 8'h00, {7'h00, port2_bad_cfg});
    done("port two");
    // small package: absent port-two latch bits cleared, pins left undriven; absent port-four pins driven low
    // port seven lies outside this block, nothing to park here
    wr(4'h2, 8'h00, 8'hc0);
    wr(4'h9, 8'h00, 8'h03);
    wr(4'h4, 8'h00, 8'h03);
    settle();
    cmp("port2_out parked", 8'h3f, port2_out);
    cmp("port4 parked", 8'h03, {4'h0, port4_out, port4_oe});
    done("small package");
    // second reset in mid-run brings back every reset value
    do_reset();
    done("second reset");
    summarize();
  end
endmodule // tb_top

//--- core/analog_port_bank.sv
// port two: latch, direction and digital/analog choice per bit
`timescale 1ns/1ns
module analog_port_bank (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        wr_latch,
  input  wire logic                        wr_dir,
  input  wire logic                        wr_digital,
  input  wire logic [gpio_pkg::width_two-1:0] wr_data,
  input  wire logic [gpio_pkg::width_two-1:0] wr_mask,
  input  wire logic [gpio_pkg::width_two-1:0] pin_in,
  input  wire logic [gpio_pkg::chan_w-1:0]    chan_sel,
  output logic      [gpio_pkg::width_two-1:0] latch,
  output logic      [gpio_pkg::width_two-1:0] dir,
  output logic      [gpio_pkg::width_two-1:0] digital,
  output logic      [gpio_pkg::width_two-1:0] read_val,
  output logic      [gpio_pkg::width_two-1:0] drive,
  output logic      [gpio_pkg::width_two-1:0] convert,
  output logic      [gpio_pkg::width_two-1:0] bad_cfg
);

  localparam int W = gpio_pkg::width_two;

  logic [W-1:0] next_latch;
  logic [W-1:0] next_dir;
  logic [W-1:0] next_digital;

  // masked bit or byte update
  always_comb begin
    next_latch   = latch;
    next_dir     = dir;
    next_digital = digital;
    if (ce) begin
      if (wr_latch)
        next_latch = (latch & ~wr_mask) | (wr_data & wr_mask);
      if (wr_dir)
        next_dir = (dir & ~wr_mask) | (wr_data & wr_mask);
      if (wr_digital)
        next_digital = (digital & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // reset puts every pin in analog input mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latch   <= gpio_pkg::latch_reset;
      dir     <= gpio_pkg::dir_reset;
      digital <= gpio_pkg::digital_reset;
    end else begin
      latch   <= next_latch;
      dir     <= next_dir;
      digital <= next_digital;
    end
  end

  // per-pin function from digital select, direction and channel
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      assign read_val[i] = digital[i] & (dir[i] ? pin_in[i] : latch[i]);
      assign drive[i]    = digital[i] & ~dir[i];
      assign convert[i]  = ~digital[i] & dir[i] &
                           (chan_sel == (gpio_pkg::chan_w)'(i));
      assign bad_cfg[i]  = ~digital[i] & ~dir[i];
    end
  endgenerate

endmodule // analog_port_bank

//--- core/gpio_pkg.sv
// shared widths, reset values and register select codes for ports zero to four
package gpio_pkg;

  // port widths
  localparam int width_zero  = 2;
  localparam int width_one   = 8;
  localparam int width_two   = 8;
  localparam int width_three = 4;
  localparam int width_four  = 2;
  localparam int data_w      = 8;
  localparam int chan_w      = 3;
  localparam int sel_w       = 4;

  // reset values
  localparam logic [7:0] dir_reset     = 8'hff; // every pin an input
  localparam logic [7:0] latch_reset   = 8'h00;
  localparam logic [7:0] pullup_reset  = 8'h00;
  localparam logic [7:0] digital_reset = 8'h00; // every port-2 pin analog
  localparam logic [7:0] dir_pad       = 8'hff; // unused direction bits
  localparam logic [7:0] data_zero     = 8'h00;

  // register select codes on the write and read ports
  typedef enum logic [3:0] {
    sel_latch_zero  = 4'h0,
    sel_latch_one   = 4'h1,
    sel_latch_two   = 4'h2,
    sel_latch_three = 4'h3,
    sel_latch_four  = 4'h4,
    sel_dir_zero    = 4'h5,
    sel_dir_one     = 4'h6,
    sel_dir_two     = 4'h7,
    sel_dir_three   = 4'h8,
    sel_dir_four    = 4'h9,
    sel_pull_zero   = 4'ha,
    sel_pull_one    = 4'hb,
    sel_pull_three  = 4'hc,
    sel_pull_four   = 4'hd,
    sel_digital     = 4'he
  } reg_sel_t;

endpackage

//--- core/gpio_ports.sv
// top of general-purpose ports zero to four
`timescale 1ns/1ns
module gpio_ports (
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  input  wire logic                                ce,
  input  wire logic                                wr_en,
  input  wire logic [gpio_pkg::sel_w-1:0]          wr_sel,
  input  wire logic [gpio_pkg::data_w-1:0]         wr_data,
  input  wire logic [gpio_pkg::data_w-1:0]         wr_mask,
  input  wire logic [gpio_pkg::sel_w-1:0]          rd_sel,
  output logic      [gpio_pkg::data_w-1:0]         rd_data,
  input  wire logic [gpio_pkg::chan_w-1:0]         converter_channel_select,
  input  wire logic [gpio_pkg::width_zero-1:0]     port0_in,
  output logic      [gpio_pkg::width_zero-1:0]     port0_out,
  output logic      [gpio_pkg::width_zero-1:0]     port0_oe,
  output logic      [gpio_pkg::width_zero-1:0]     port0_pullup,
  input  wire logic [gpio_pkg::width_one-1:0]      port1_in,
  output logic      [gpio_pkg::width_one-1:0]      port1_out,
  output logic      [gpio_pkg::width_one-1:0]      port1_oe,
  output logic      [gpio_pkg::width_one-1:0]      port1_pullup,
  input  wire logic [gpio_pkg::width_two-1:0]      port2_in,
  output logic      [gpio_pkg::width_two-1:0]      port2_out,
  output logic      [gpio_pkg::width_two-1:0]      port2_oe,
  output logic      [gpio_pkg::width_two-1:0]      port2_convert,
  output logic                                     port2_bad_cfg,
  input  wire logic [gpio_pkg::width_three-1:0]    port3_in,
  output logic      [gpio_pkg::width_three-1:0]    port3_out,
  output logic      [gpio_pkg::width_three-1:0]    port3_oe,
  output logic      [gpio_pkg::width_three-1:0]    port3_pullup,
  input  wire logic [gpio_pkg::width_four-1:0]     port4_in,
  output logic      [gpio_pkg::width_four-1:0]     port4_out,
  output logic      [gpio_pkg::width_four-1:0]     port4_oe,
  output logic      [gpio_pkg::width_four-1:0]     port4_pullup
);

  localparam int W0 = gpio_pkg::width_zero;
  localparam int W1 = gpio_pkg::width_one;
  localparam int W2 = gpio_pkg::width_two;
  localparam int W3 = gpio_pkg::width_three;
  localparam int W4 = gpio_pkg::width_four;
  localparam int DW = gpio_pkg::data_w;

  // write strobes decoded from the select code
  logic wr_latch_zero;
  logic wr_latch_one;
  logic wr_latch_two;
  logic wr_latch_three;
  logic wr_latch_four;
  logic wr_dir_zero;
  logic wr_dir_one;
  logic wr_dir_two;
  logic wr_dir_three;
  logic wr_dir_four;
  logic wr_pull_zero;
  logic wr_pull_one;
  logic wr_pull_three;
  logic wr_pull_four;
  logic wr_digital;

  assign wr_latch_zero  = wr_en && wr_sel == gpio_pkg::sel_latch_zero;
  assign wr_latch_one   = wr_en && wr_sel == gpio_pkg::sel_latch_one;
  assign wr_latch_two   = wr_en && wr_sel == gpio_pkg::sel_latch_two;
  assign wr_latch_three = wr_en && wr_sel == gpio_pkg::sel_latch_three;
  assign wr_latch_four  = wr_en && wr_sel == gpio_pkg::sel_latch_four;
  assign wr_dir_zero    = wr_en && wr_sel == gpio_pkg::sel_dir_zero;
  assign wr_dir_one     = wr_en && wr_sel == gpio_pkg::sel_dir_one;
  assign wr_dir_two     = wr_en && wr_sel == gpio_pkg::sel_dir_two;
  assign wr_dir_three   = wr_en && wr_sel == gpio_pkg::sel_dir_three;
  assign wr_dir_four    = wr_en && wr_sel == gpio_pkg::sel_dir_four;
  assign wr_pull_zero   = wr_en && wr_sel == gpio_pkg::sel_pull_zero;
  assign wr_pull_one    = wr_en && wr_sel == gpio_pkg::sel_pull_one;
  assign wr_pull_three  = wr_en && wr_sel == gpio_pkg::sel_pull_three;
  assign wr_pull_four   = wr_en && wr_sel == gpio_pkg::sel_pull_four;
  assign wr_digital     = wr_en && wr_sel == gpio_pkg::sel_digital;

  // register contents of each bank
  logic [W0-1:0] latch_reg_zero;
  logic [W0-1:0] dir_reg_zero;
  logic [W0-1:0] pullup_reg_zero;
  logic [W0-1:0] read_zero;
  logic [W1-1:0] latch_reg_one;
  logic [W1-1:0] dir_reg_one;
  logic [W1-1:0] pullup_reg_one;
  logic [W1-1:0] read_one;
  logic [W2-1:0] latch_reg_two;
  logic [W2-1:0] dir_reg_two;
  logic [W2-1:0] analog_digital_select_reg;
  logic [W2-1:0] read_two;
  logic [W2-1:0] drive_two;
  logic [W2-1:0] convert_two;
  logic [W2-1:0] bad_two;
  logic [W3-1:0] latch_reg_three;
  logic [W3-1:0] dir_reg_three;
  logic [W3-1:0] pullup_reg_three;
  logic [W3-1:0] read_three;
  logic [W4-1:0] latch_reg_four;
  logic [W4-1:0] dir_reg_four;
  logic [W4-1:0] pullup_reg_four;
  logic [W4-1:0] read_four;

  // port zero: two pins with pull-up
  port_bank #(.WIDTH(W0), .HAS_PULLUP(1'b1)) u_port_zero (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .wr_latch (wr_latch_zero),
    .wr_dir   (wr_dir_zero),
    .wr_pull  (wr_pull_zero),
    .wr_data  (wr_data[W0-1:0]),
    .wr_mask  (wr_mask[W0-1:0]),
    .pin_in   (port0_in),
    .latch    (latch_reg_zero),
    .dir      (dir_reg_zero),
    .pull_en  (pullup_reg_zero),
    .read_val (read_zero)
  );

  // port one: eight pins with pull-up
  port_bank #(.WIDTH(W1), .HAS_PULLUP(1'b1)) u_port_one (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .wr_latch (wr_latch_one),
    .wr_dir   (wr_dir_one),
    .wr_pull  (wr_pull_one),
    .wr_data  (wr_data[W1-1:0]),
    .wr_mask  (wr_mask[W1-1:0]),
    .pin_in   (port1_in),
    .latch    (latch_reg_one),
    .dir      (dir_reg_one),
    .pull_en  (pullup_reg_one),
    .read_val (read_one)
  );

  // port two: shared with converter inputs, no pull-up
  analog_port_bank u_port_two (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .ce         (ce),
    .wr_latch   (wr_latch_two),
    .wr_dir     (wr_dir_two),
    .wr_digital (wr_digital),
    .wr_data    (wr_data[W2-1:0]),
    .wr_mask    (wr_mask[W2-1:0]),
    .pin_in     (port2_in),
    .chan_sel   (converter_channel_select),
    .latch      (latch_reg_two),
    .dir        (dir_reg_two),
    .digital    (analog_digital_select_reg),
    .read_val   (read_two),
    .drive      (drive_two),
    .convert    (convert_two),
    .bad_cfg    (bad_two)
  );

  // port three: four pins with pull-up
  port_bank #(.WIDTH(W3), .HAS_PULLUP(1'b1)) u_port_three (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .wr_latch (wr_latch_three),
    .wr_dir   (wr_dir_three),
    .wr_pull  (wr_pull_three),
    .wr_data  (wr_data[W3-1:0]),
    .wr_mask  (wr_mask[W3-1:0]),
    .pin_in   (port3_in),
    .latch    (latch_reg_three),
    .dir      (dir_reg_three),
    .pull_en  (pullup_reg_three),
    .read_val (read_three)
  );

  // port four: two pins with pull-up
  port_bank #(.WIDTH(W4), .HAS_PULLUP(1'b1)) u_port_four (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .ce       (ce),
    .wr_latch (wr_latch_four),
    .wr_dir   (wr_dir_four),
    .wr_pull  (wr_pull_four),
    .wr_data  (wr_data[W4-1:0]),
    .wr_mask  (wr_mask[W4-1:0]),
    .pin_in   (port4_in),
    .latch    (latch_reg_four),
    .dir      (dir_reg_four),
    .pull_en  (pullup_reg_four),
    .read_val (read_four)
  );

  // next values of every registered output but the pin outputs, which take the latches
  logic [DW-1:0] next_rd_data;
  logic [W0-1:0] next_port0_oe;
  logic [W0-1:0] next_port0_pullup;
  logic [W1-1:0] next_port1_oe;
  logic [W1-1:0] next_port1_pullup;
  logic [W2-1:0] next_port2_oe;
  logic [W2-1:0] next_port2_convert;
  logic          next_port2_bad_cfg;
  logic [W3-1:0] next_port3_oe;
  logic [W3-1:0] next_port3_pullup;
  logic [W4-1:0] next_port4_oe;
  logic [W4-1:0] next_port4_pullup;

  // read mux; narrow direction registers read ones above their pins
  always_comb begin
    next_rd_data = gpio_pkg::data_zero;
    unique case (rd_sel)
      gpio_pkg::sel_latch_zero:
        next_rd_data = {{(DW-W0){1'b0}}, read_zero};
      gpio_pkg::sel_latch_one:
        next_rd_data = read_one;
      gpio_pkg::sel_latch_two:
        next_rd_data = read_two;
      gpio_pkg::sel_latch_three:
        next_rd_data = {{(DW-W3){1'b0}}, read_three};
      gpio_pkg::sel_latch_four:
        next_rd_data = {{(DW-W4){1'b0}}, read_four};
      gpio_pkg::sel_dir_zero:
        next_rd_data = {gpio_pkg::dir_pad[DW-1:W0], dir_reg_zero};
      gpio_pkg::sel_dir_one:
        next_rd_data = dir_reg_one;
      gpio_pkg::sel_dir_two:
        next_rd_data = dir_reg_two;
      gpio_pkg::sel_dir_three:
        next_rd_data = {gpio_pkg::dir_pad[DW-1:W3], dir_reg_three};
      gpio_pkg::sel_dir_four:
        next_rd_data = {gpio_pkg::dir_pad[DW-1:W4], dir_reg_four};
      gpio_pkg::sel_pull_zero:
        next_rd_data = {{(DW-W0){1'b0}}, pullup_reg_zero};
      gpio_pkg::sel_pull_one:
        next_rd_data = pullup_reg_one;
      gpio_pkg::sel_pull_three:
        next_rd_data = {{(DW-W3){1'b0}}, pullup_reg_three};
      gpio_pkg::sel_pull_four:
        next_rd_data = {{(DW-W4){1'b0}}, pullup_reg_four};
      gpio_pkg::sel_digital:
        next_rd_data = analog_digital_select_reg;
      default:
        next_rd_data = gpio_pkg::data_zero; // unused code reads zero
    endcase
  end

  // pin drive and pull-up; pull-up only on input pins
  always_comb begin
    next_port0_oe      = ~dir_reg_zero;
    next_port0_pullup  = pullup_reg_zero & dir_reg_zero;
    next_port1_oe      = ~dir_reg_one;
    next_port1_pullup  = pullup_reg_one & dir_reg_one;
    next_port2_oe      = drive_two;
    next_port2_convert = convert_two;
    next_port2_bad_cfg = |bad_two;
    next_port3_oe      = ~dir_reg_three;
    next_port3_pullup  = pullup_reg_three & dir_reg_three;
    next_port4_oe      = ~dir_reg_four;
    next_port4_pullup  = pullup_reg_four & dir_reg_four;
  end

  // output flops; reset leaves all pins undriven inputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data       <= gpio_pkg::data_zero;
      port0_out     <= gpio_pkg::latch_reset[W0-1:0];
      port0_oe      <= ~gpio_pkg::dir_reset[W0-1:0];
      port0_pullup  <= gpio_pkg::pullup_reset[W0-1:0];
      port1_out     <= gpio_pkg::latch_reset[W1-1:0];
      port1_oe      <= ~gpio_pkg::dir_reset[W1-1:0];
      port1_pullup  <= gpio_pkg::pullup_reset[W1-1:0];
      port2_out     <= gpio_pkg::latch_reset[W2-1:0];
      port2_oe      <= gpio_pkg::digital_reset;
      port2_convert <= gpio_pkg::data_zero;
      port2_bad_cfg <= 1'b0;
      port3_out     <= gpio_pkg::latch_reset[W3-1:0];
      port3_oe      <= ~gpio_pkg::dir_reset[W3-1:0];
      port3_pullup  <= gpio_pkg::pullup_reset[W3-1:0];
      port4_out     <= gpio_pkg::latch_reset[W4-1:0];
      port4_oe      <= ~gpio_pkg::dir_reset[W4-1:0];
      port4_pullup  <= gpio_pkg::pullup_reset[W4-1:0];
    end else if (ce) begin
      rd_data       <= next_rd_data;
      port0_out     <= latch_reg_zero;
      port0_oe      <= next_port0_oe;
      port0_pullup  <= next_port0_pullup;
      port1_out     <= latch_reg_one;
      port1_oe      <= next_port1_oe;
      port1_pullup  <= next_port1_pullup;
      port2_out     <= latch_reg_two;
      port2_oe      <= next_port2_oe;
      port2_convert <= next_port2_convert;
      port2_bad_cfg <= next_port2_bad_cfg;
      port3_out     <= latch_reg_three;
      port3_oe      <= next_port3_oe;
      port3_pullup  <= next_port3_pullup;
      port4_out     <= latch_reg_four;
      port4_oe      <= next_port4_oe;
      port4_pullup  <= next_port4_pullup;
    end
  end

endmodule // gpio_ports

//--- core/port_bank.sv
// one digital port: output latch, direction and optional pull-up per bit
`timescale 1ns/1ns
module port_bank #(
  parameter int WIDTH      = 8,
  parameter bit HAS_PULLUP = 1'b1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             wr_latch,
  input  wire logic             wr_dir,
  input  wire logic             wr_pull,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [WIDTH-1:0] wr_mask,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] latch,
  output logic      [WIDTH-1:0] dir,
  output logic      [WIDTH-1:0] pull_en,
  output logic      [WIDTH-1:0] read_val
);

  logic [WIDTH-1:0] next_latch;
  logic [WIDTH-1:0] next_dir;
  logic [WIDTH-1:0] next_pull_en;

  // masked bit or byte update of each register
  always_comb begin
    next_latch   = latch;
    next_dir     = dir;
    next_pull_en = pull_en;
    if (ce) begin
      if (wr_latch)
        next_latch = (latch & ~wr_mask) | (wr_data & wr_mask);
      if (wr_dir)
        next_dir = (dir & ~wr_mask) | (wr_data & wr_mask);
      if (wr_pull && HAS_PULLUP)
        next_pull_en = (pull_en & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // reset leaves every pin an input
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latch   <= gpio_pkg::latch_reset[WIDTH-1:0];
      dir     <= gpio_pkg::dir_reset[WIDTH-1:0];
      pull_en <= gpio_pkg::pullup_reset[WIDTH-1:0];
    end else begin
      latch   <= next_latch;
      dir     <= next_dir;
      pull_en <= next_pull_en;
    end
  end

  // read: pin level for inputs, latch for outputs
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_read
      assign read_val[i] = dir[i] ? pin_in[i] : latch[i];
    end
  endgenerate

endmodule // port_bank
